// ---- mws_map.svh ----
// Constants of the memory word search unit: limits, widths, reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MWS_MAP_SVH
`define MWS_MAP_SVH

`define MWS_WORD_W      16
`define MWS_ADDR_W      14
`define MWS_N_MIN       16'h0001
`define MWS_N_MAX       16'h6655
`define MWS_DM_WORDS    6656
`define MWS_RESULT_OFS  14'h0001
`define MWS_ZERO_BCD    16'h0000

`endif

// ---- mws_pkg.sv ----
// Types and helper functions of the memory word search unit.
// Assumes mws_map.svh sits in the include path.
`include "mws_map.svh"

package mws_pkg;

    typedef logic [`MWS_WORD_W-1:0] mws_word_t;
    typedef logic [`MWS_ADDR_W-1:0] mws_addr_t;

    // Memory area codes seen on the operand and memory ports
    typedef enum logic [2:0] {
        MWS_AREA_IR = 3'h0,
        MWS_AREA_SR = 3'h1,
        MWS_AREA_AR = 3'h2,
        MWS_AREA_DM = 3'h3,
        MWS_AREA_HR = 3'h4,
        MWS_AREA_TC = 3'h5,
        MWS_AREA_LR = 3'h6,
        MWS_AREA_XX = 3'h7
    } mws_area_t;

    typedef enum logic [2:0] {
        MWS_ST_IDLE = 3'b000,
        MWS_ST_RD_N = 3'b001,
        MWS_ST_RD_C = 3'b010,
        MWS_ST_SCAN = 3'b011,
        MWS_ST_WR   = 3'b100
    } mws_state_t;

    function automatic logic mws_is_bcd(input mws_word_t w);
        mws_is_bcd = (w[15:12] < 4'hA) && (w[11:8] < 4'hA) &&
                     (w[7:4] < 4'hA) && (w[3:0] < 4'hA);
    endfunction : mws_is_bcd

    function automatic mws_addr_t mws_bcd2bin(input mws_word_t w);
        mws_bcd2bin = 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100 +
                      14'(w[7:4]) * 14'd10 + 14'(w[3:0]);
    endfunction : mws_bcd2bin

endpackage : mws_pkg

// ---- mws_bcd_if.sv ----
// Carrier between the search core and a four-digit BCD incrementer.
// Assumes the package compiled first.
`timescale 1ns/1ps
`default_nettype none

interface mws_bcd_if;
    import mws_pkg::*;
    mws_word_t value;
    mws_word_t next;
    modport user (output value, input next);
    modport inc  (input value, output next);
endinterface : mws_bcd_if

`default_nettype wire

// ---- mws_bcd_inc.sv ----
// Four-digit BCD incrementer, purely combinational, wraps 9999 to 0000.
// Assumes a BCD value on the carrier input.
`timescale 1ns/1ps
`default_nettype none

module mws_bcd_inc (
    // Carrier
    mws_bcd_if.inc bi
);
    import mws_pkg::*;

    logic [4:0] carry;

    assign carry[0] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_digit
            wire logic [3:0] d = bi.value[4*g +: 4];
            assign carry[g+1] = carry[g] && (d == 4'h9);
            assign bi.next[4*g +: 4] = !carry[g] ? d :
                                       (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
        end
    endgenerate

endmodule : mws_bcd_inc

`default_nettype wire

// ---- mws_word_search.sv ----
// Word search unit: finds the first data word equal to a comparison word.
// Assumes a same-clock memory answering each read exactly one cycle later.
//
// Functional notes
// - Execute condition low: no search, flags kept.
// - Compare words first through first plus count-1.
// - Match sets flag, lowest position to next word.
// - Data-memory hit reports absolute word address.
// - Other-area hit reports distance from range start.
// - No match clears flag, result word untouched.
// - Bad indirect pointer raises error flag.
// - Count not BCD 0001..6655 raises error.
// - Count taken as constant or memory word.
`timescale 1ns/1ps
`default_nettype none
`include "mws_map.svh"

module mws_word_search #(
    parameter int DM_WORDS = `MWS_DM_WORDS
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               srst,
    // Instruction sequencer
    input  wire logic               start,
    input  wire logic               exec_cond,
    input  wire logic               n_is_const,
    input  wire mws_pkg::mws_word_t n_value,
    input  wire mws_pkg::mws_area_t n_area,
    input  wire logic               n_indirect,
    input  wire mws_pkg::mws_word_t r1_addr,
    input  wire mws_pkg::mws_area_t r1_area,
    input  wire logic               r1_indirect,
    input  wire mws_pkg::mws_word_t c_addr,
    input  wire mws_pkg::mws_area_t c_area,
    input  wire logic               c_indirect,
    output var  logic               done,
    output var  logic               busy,
    output var  logic               match_flag,
    output var  logic               operand_error_flag,
    // Data memory port
    output var  logic               mem_rd_en,
    output var  mws_pkg::mws_area_t mem_rd_area,
    output var  mws_pkg::mws_addr_t mem_rd_addr,
    input  wire mws_pkg::mws_word_t mem_rd_data,
    output var  logic               mem_wr_en,
    output var  mws_pkg::mws_area_t mem_wr_area,
    output var  mws_pkg::mws_addr_t mem_wr_addr,
    output var  mws_pkg::mws_word_t mem_wr_data
);
    import mws_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Operand checks

    mws_state_t state_r;
    mws_area_t  r1_area_r;
    mws_addr_t  r1_bin_r, c_bin_r, cnt_bin_r, rd_idx_r, cmp_cnt_r;
    mws_word_t  cmp_r;
    logic       data_vld_r;
    logic       ptr_bad, n_bad_c, n_bad_m, hit, last;

    function automatic logic ptr_ok(input mws_word_t p);
        ptr_ok = mws_is_bcd(p) && (int'(mws_bcd2bin(p)) < DM_WORDS);
    endfunction : ptr_ok

    always_comb begin
        ptr_bad = (r1_indirect && !ptr_ok(r1_addr)) ||
                  (c_indirect && !ptr_ok(c_addr)) ||
                  (!n_is_const && n_indirect && !ptr_ok(n_value));
        n_bad_c = !mws_is_bcd(n_value) || (n_value < `MWS_N_MIN) ||
                  (n_value > `MWS_N_MAX);
        n_bad_m = !mws_is_bcd(mem_rd_data) || (mem_rd_data < `MWS_N_MIN) ||
                  (mem_rd_data > `MWS_N_MAX);
        hit     = (state_r == MWS_ST_SCAN) && data_vld_r && (mem_rd_data == cmp_r);
        last    = (cmp_cnt_r == 14'(cnt_bin_r - 14'd1));
    end

    ////////////////////////////////////////////////////////////////////////////
    // BCD position counters

    mws_bcd_if pos_if ();
    mws_bcd_if abs_if ();
    mws_word_t pos_bcd_r, abs_bcd_r;

    assign pos_if.value = pos_bcd_r;
    assign abs_if.value = abs_bcd_r;

    mws_bcd_inc u_pos_inc (.bi(pos_if));
    mws_bcd_inc u_abs_inc (.bi(abs_if));

    always_ff @(posedge core_clk) begin
        if (srst || (state_r == MWS_ST_IDLE)) begin
            pos_bcd_r <= `MWS_ZERO_BCD;
            abs_bcd_r <= r1_addr;
        end else if (state_r == MWS_ST_SCAN && data_vld_r && !hit) begin
            pos_bcd_r <= pos_if.next;
            abs_bcd_r <= abs_if.next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r   <= MWS_ST_IDLE;
            r1_area_r <= MWS_AREA_IR;
            r1_bin_r  <= '0;
            c_bin_r   <= '0;
            cnt_bin_r <= '0;
            cmp_r     <= '0;
            rd_idx_r  <= '0;
            cmp_cnt_r <= '0;
        end else begin
            unique case (state_r)
                MWS_ST_IDLE: begin
                    rd_idx_r  <= '0;
                    cmp_cnt_r <= '0;
                    if (start && exec_cond && !ptr_bad) begin
                        r1_area_r <= r1_indirect ? MWS_AREA_DM : r1_area;
                        r1_bin_r  <= mws_bcd2bin(r1_addr);
                        c_bin_r   <= mws_bcd2bin(c_addr);
                        cnt_bin_r <= mws_bcd2bin(n_value);
                        if (!n_is_const)
                            state_r <= MWS_ST_RD_N;
                        else if (!n_bad_c)
                            state_r <= MWS_ST_RD_C;
                    end
                end
                MWS_ST_RD_N: begin
                    if (data_vld_r) begin
                        cnt_bin_r <= mws_bcd2bin(mem_rd_data);
                        state_r   <= n_bad_m ? MWS_ST_IDLE : MWS_ST_RD_C;
                    end
                end
                MWS_ST_RD_C: begin
                    if (data_vld_r) begin
                        cmp_r   <= mem_rd_data;
                        state_r <= MWS_ST_SCAN;
                    end
                end
                MWS_ST_SCAN: begin
                    if (rd_idx_r != cnt_bin_r)
                        rd_idx_r <= 14'(rd_idx_r + 14'd1);
                    if (hit)
                        state_r <= MWS_ST_WR;
                    else if (data_vld_r) begin
                        cmp_cnt_r <= 14'(cmp_cnt_r + 14'd1);
                        if (last)
                            state_r <= MWS_ST_IDLE;
                    end
                end
                MWS_ST_WR: state_r <= MWS_ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory port

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_rd_en   <= 1'b0;
            mem_rd_area <= MWS_AREA_IR;
            mem_rd_addr <= '0;
            data_vld_r  <= 1'b0;
        end else begin
            data_vld_r <= mem_rd_en;
            mem_rd_en  <= 1'b0;
            if (state_r == MWS_ST_IDLE && start && exec_cond && !ptr_bad) begin
                if (!n_is_const) begin
                    mem_rd_en   <= 1'b1;
                    mem_rd_area <= n_indirect ? MWS_AREA_DM : n_area;
                    mem_rd_addr <= mws_bcd2bin(n_value);
                end else if (!n_bad_c) begin
                    mem_rd_en   <= 1'b1;
                    mem_rd_area <= c_indirect ? MWS_AREA_DM : c_area;
                    mem_rd_addr <= mws_bcd2bin(c_addr);
                end
            end else if (state_r == MWS_ST_RD_N && data_vld_r && !n_bad_m) begin
                mem_rd_en   <= 1'b1;
                mem_rd_area <= c_indirect ? MWS_AREA_DM : c_area;
                mem_rd_addr <= c_bin_r;
            end else if (state_r == MWS_ST_SCAN && !hit && rd_idx_r != cnt_bin_r &&
                         !(data_vld_r && last)) begin
                mem_rd_en   <= 1'b1;
                mem_rd_area <= r1_area_r;
                mem_rd_addr <= 14'(r1_bin_r + rd_idx_r);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            mem_wr_en   <= 1'b0;
            mem_wr_area <= MWS_AREA_IR;
            mem_wr_addr <= '0;
            mem_wr_data <= '0;
        end else begin
            mem_wr_en <= hit;
            if (hit) begin
                mem_wr_area <= c_indirect ? MWS_AREA_DM : c_area;
                mem_wr_addr <= 14'(c_bin_r + `MWS_RESULT_OFS);
                mem_wr_data <= (r1_area_r == MWS_AREA_DM) ? abs_bcd_r
                                                          : pos_bcd_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flags and completion

    always_ff @(posedge core_clk) begin
        if (srst) begin
            match_flag         <= 1'b0;
            operand_error_flag <= 1'b0;
            done               <= 1'b0;
            busy               <= 1'b0;
        end else begin
            done <= 1'b0;
            if (state_r == MWS_ST_IDLE && start) begin
                busy <= exec_cond;
                if (!exec_cond)
                    done <= 1'b1;
                else if (ptr_bad || (n_is_const && n_bad_c)) begin
                    operand_error_flag <= 1'b1;
                    done               <= 1'b1;
                    busy               <= 1'b0;
                end else
                    operand_error_flag <= 1'b0;
            end else if (state_r == MWS_ST_RD_N && data_vld_r && n_bad_m) begin
                operand_error_flag <= 1'b1;
                done               <= 1'b1;
                busy               <= 1'b0;
            end else if (hit) begin
                match_flag <= 1'b1;
            end else if (state_r == MWS_ST_WR) begin
                done <= 1'b1;
                busy <= 1'b0;
            end else if (state_r == MWS_ST_SCAN && data_vld_r && last) begin
                match_flag <= 1'b0;
                done       <= 1'b1;
                busy       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    logic idle_go;
    assign idle_go = (state_r == MWS_ST_IDLE) && start && exec_cond;

    a_skip_keeps: assert property ((state_r == MWS_ST_IDLE) && start && !exec_cond
        |=> done && $stable(match_flag) && $stable(operand_error_flag) && !mem_wr_en)
        else $error("skipped search changed state");
    a_scan_range: assert property (mem_rd_en && state_r == MWS_ST_SCAN
        |-> mem_rd_addr >= r1_bin_r && mem_rd_addr < 14'(r1_bin_r + cnt_bin_r))
        else $error("scan read outside range");
    a_hit_write: assert property (hit |=> mem_wr_en && match_flag ##1 done)
        else $error("match not reported");
    a_dm_result: assert property (mem_wr_en && r1_area_r == MWS_AREA_DM
        |-> mem_wr_data == abs_bcd_r)
        else $error("absolute address wrong");
    a_rel_result: assert property (mem_wr_en && r1_area_r != MWS_AREA_DM
        |-> mem_wr_data == pos_bcd_r && mws_is_bcd(mem_wr_data))
        else $error("relative position wrong");
    a_miss_clear: assert property (state_r == MWS_ST_SCAN && last && !hit
        && data_vld_r |=> !match_flag && done && !mem_wr_en)
        else $error("miss not handled");
    a_ptr_error: assert property (idle_go && ptr_bad
        |=> operand_error_flag && done && !mem_rd_en)
        else $error("bad pointer not flagged");
    a_count_error: assert property (idle_go && !ptr_bad && n_is_const && n_bad_c
        |=> operand_error_flag && done ##1 state_r == MWS_ST_IDLE)
        else $error("bad count not flagged");
    a_count_read: assert property (idle_go && !ptr_bad && !n_is_const
        |=> mem_rd_en && mem_rd_addr == mws_bcd2bin($past(n_value)))
        else $error("count word not fetched");
    a_one_per_clk: assert property (state_r == MWS_ST_SCAN && !hit && !last
        && data_vld_r |=> cmp_cnt_r == 14'($past(cmp_cnt_r) + 14'd1))
        else $error("scan not one word per clock");

    c_hit:   cover property (hit ##2 done);
    c_miss:  cover property (state_r == MWS_ST_SCAN && data_vld_r && last && !hit);
    c_error: cover property (idle_go ##1 operand_error_flag);
    c_skip:  cover property ((state_r == MWS_ST_IDLE) && start && !exec_cond);

endmodule : mws_word_search

`default_nettype wire

// ---- mws_mem_model.sv ----
// Partner model: controller data memory, one-cycle read answer, no stalls.
// Assumes mws_pkg compiled first; the bench preloads and inspects mem directly.
`timescale 1ns/1ps
`default_nettype none

module mws_mem_model (
    // Clock
    input  wire logic               core_clk,
    // Read port
    input  wire logic               rd_en,
    input  wire mws_pkg::mws_area_t rd_area,
    input  wire mws_pkg::mws_addr_t rd_addr,
    output var  mws_pkg::mws_word_t rd_data,
    // Write port
    input  wire logic               wr_en,
    input  wire mws_pkg::mws_area_t wr_area,
    input  wire mws_pkg::mws_addr_t wr_addr,
    input  wire mws_pkg::mws_word_t wr_data
);
    import mws_pkg::*;
    mws_word_t mem [0:131071];
    initial begin
        rd_data = 16'h0000;
        foreach (mem[i]) mem[i] = 16'h0000;
    end
    // Valid only in the cycle after a read; scrambled otherwise
    always @(posedge core_clk) begin
        if (rd_en)
            rd_data <= mem[{rd_area, rd_addr}];
        else
            rd_data <= ~rd_data;
    end
    always @(posedge core_clk) begin
        if (wr_en)
            mem[{wr_area, wr_addr}] <= wr_data;
    end
endmodule : mws_mem_model

`default_nettype wire

// ---- mws_word_search_bench.sv ----
// Self-checking bench of the word search unit against a memory model.
// Assumes the package, carrier, incrementer and search unit compiled first.
`timescale 1ns/1ps
`default_nettype none

module mws_word_search_bench;
    import mws_pkg::*;
    logic      core_clk, srst, start, exec_cond, n_is_const, n_indirect;
    logic      r1_indirect, c_indirect, done, busy, match_flag;
    logic      operand_error_flag, mem_rd_en, mem_wr_en;
    mws_word_t n_value, r1_addr, c_addr, mem_rd_data, mem_wr_data;
    mws_area_t n_area, r1_area, c_area, mem_rd_area, mem_wr_area;
    mws_addr_t mem_rd_addr, mem_wr_addr;
    int        errors, n_compared;

    mws_word_search mws_word_search_i (.core_clk(core_clk), .srst(srst), .start(start),
        .exec_cond(exec_cond), .n_is_const(n_is_const), .n_value(n_value),
        .n_area(n_area), .n_indirect(n_indirect), .r1_addr(r1_addr), .r1_area(r1_area),
        .r1_indirect(r1_indirect), .c_addr(c_addr), .c_area(c_area),
        .c_indirect(c_indirect), .done(done), .busy(busy), .match_flag(match_flag),
        .operand_error_flag(operand_error_flag), .mem_rd_en(mem_rd_en),
        .mem_rd_area(mem_rd_area), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data),
        .mem_wr_en(mem_wr_en), .mem_wr_area(mem_wr_area), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data));
    mws_mem_model mws_mem_model_i (.core_clk(core_clk), .rd_en(mem_rd_en),
        .rd_area(mem_rd_area), .rd_addr(mem_rd_addr), .rd_data(mem_rd_data),
        .wr_en(mem_wr_en), .wr_area(mem_wr_area), .wr_addr(mem_wr_addr),
        .wr_data(mem_wr_data));

    ////////////////////////////////////////////////////////////////////////////
    task automatic put(input mws_area_t a, input int i, input mws_word_t v);
        mws_mem_model_i.mem[{a, 14'(i)}] = v;
    endtask : put
    function automatic mws_word_t get(input mws_area_t a, input int i);
        return mws_mem_model_i.mem[{a, 14'(i)}];
    endfunction : get
    task automatic chk_w(input mws_word_t got, input mws_word_t exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t: %s is %h, want %h", $time, what, got, exp);
        end
    endtask : chk_w
    task automatic chk_b(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t: %s is %b, want %b", $time, what, got, exp);
        end
    endtask : chk_b
    task automatic ops(input logic nc, input mws_word_t nv, input mws_area_t na,
                       input mws_word_t r1, input mws_area_t ra, input mws_word_t c,
                       input mws_area_t ca);
        n_is_const = nc;
        n_value = nv;
        n_area = na;
        r1_addr = r1;
        r1_area = ra;
        c_addr = c;
        c_area = ca;
    endtask : ops
    // Start pulse, then bounded wait for the done pulse
    task automatic fire(input logic ec);
        int k;
        @(negedge core_clk);
        start = 1'b1;
        exec_cond = ec;
        @(negedge core_clk);
        start = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 8000) begin
            chk_b(busy, 1'b1, "busy in search");
            @(negedge core_clk);
            k++;
        end
        if (k == 8000) begin
            errors++;
            $display("[FAIL] %0t: no done", $time);
            end_sim();
        end else begin
            chk_b(busy, 1'b0, "busy at done");
        end
    endtask : fire
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_dm_hit;
        put(MWS_AREA_DM, 0, 16'hFFFF);
        put(MWS_AREA_DM, 9, 16'hFFFF);
        put(MWS_AREA_DM, 12, 16'hFFFF);
        put(MWS_AREA_DM, 15, 16'hFFFF);
        ops(1'b1, 16'h0010, MWS_AREA_IR, 16'h0010, MWS_AREA_DM, 16'h0000, MWS_AREA_DM);
        fire(1'b1);
        chk_b(match_flag, 1'b1, "dm match");
        chk_w(get(MWS_AREA_DM, 1), 16'h0012, "dm result");
        chk_b(operand_error_flag, 1'b0, "dm error");
        $display("test dm hit over");
    endtask : t_dm_hit
    task automatic t_cnt_err;
        mws_word_t bad [5] = '{16'h0000, 16'h6656, 16'h9999, 16'h00A1, 16'hF001};
        foreach (bad[i]) begin
            ops(1'b1, bad[i], MWS_AREA_IR, 16'h0010, MWS_AREA_DM, 16'h0000, MWS_AREA_DM);
            fire(1'b1);
            chk_b(operand_error_flag, 1'b1, "count error");
            chk_b(match_flag, 1'b1, "match kept on error");
        end
        $display("test count errors over");
    endtask : t_cnt_err
    task automatic t_skip_miss;
        put(MWS_AREA_HR, 10, 16'h4321);
        put(MWS_AREA_HR, 11, 16'h5A5A);
        put(MWS_AREA_IR, 199, 16'h4321);
        put(MWS_AREA_IR, 205, 16'h4321);
        ops(1'b1, 16'h0005, MWS_AREA_IR, 16'h0200, MWS_AREA_IR, 16'h0010, MWS_AREA_HR);
        fire(1'b0);
        chk_b(match_flag, 1'b1, "skip match");
        chk_b(operand_error_flag, 1'b1, "skip error");
        fire(1'b1);
        chk_b(match_flag, 1'b0, "miss match");
        chk_b(operand_error_flag, 1'b0, "miss error");
        chk_w(get(MWS_AREA_HR, 11), 16'h5A5A, "miss result");
        $display("test skip and miss over");
    endtask : t_skip_miss
    task automatic t_rel_hit;
        put(MWS_AREA_HR, 0, 16'h1234);
        put(MWS_AREA_IR, 13, 16'h1234);
        put(MWS_AREA_IR, 114, 16'h1234);
        put(MWS_AREA_IR, 115, 16'h1234);
        ops(1'b1, 16'h0101, MWS_AREA_IR, 16'h0014, MWS_AREA_IR, 16'h0000, MWS_AREA_HR);
        fire(1'b1);
        chk_b(match_flag, 1'b1, "rel match");
        chk_w(get(MWS_AREA_HR, 1), 16'h0100, "rel result");
        $display("test relative hit over");
    endtask : t_rel_hit
    task automatic t_fetch;
        put(MWS_AREA_DM, 200, 16'h7777);
        put(MWS_AREA_DM, 301, 16'h7777);
        for (int a = 0; a < 7; a++) begin
            put(mws_area_t'(a), 50, 16'h0003);
            put(MWS_AREA_DM, 201, 16'h0000);
            ops(1'b0, 16'h0050, mws_area_t'(a), 16'h0300, MWS_AREA_DM, 16'h0200,
                MWS_AREA_DM);
            fire(1'b1);
            chk_w(get(MWS_AREA_DM, 201), 16'h0301, "fetched count");
        end
        // Fetched count above the limit
        put(MWS_AREA_HR, 50, 16'h6656);
        ops(1'b0, 16'h0050, MWS_AREA_HR, 16'h0300, MWS_AREA_DM, 16'h0200, MWS_AREA_DM);
        fire(1'b1);
        chk_b(operand_error_flag, 1'b1, "fetched count error");
        chk_b(match_flag, 1'b1, "match kept on fetch error");
        $display("test fetched count over");
    endtask : t_fetch
    task automatic t_max;
        put(MWS_AREA_HR, 20, 16'hBEEF);
        put(MWS_AREA_DM, 6654, 16'hBEEF);
        ops(1'b1, 16'h6655, MWS_AREA_IR, 16'h0000, MWS_AREA_DM, 16'h0020, MWS_AREA_HR);
        fire(1'b1);
        chk_b(operand_error_flag, 1'b0, "max count error");
        chk_w(get(MWS_AREA_HR, 21), 16'h6654, "last word result");
        $display("test max count over");
    endtask : t_max
    task automatic t_indirect;
        for (int k = 0; k < 3; k++) begin
            ops(1'b1, 16'h0010, MWS_AREA_IR, 16'h0010, MWS_AREA_DM, 16'h0000, MWS_AREA_DM);
            fire(1'b1);
            chk_b(operand_error_flag, 1'b0, "clean run error");
            r1_indirect = (k == 0);
            c_indirect = (k == 1);
            n_indirect = (k == 2);
            n_is_const = (k != 2);
            r1_addr = (k == 0) ? 16'h6656 : 16'h0010;
            c_addr = (k == 1) ? 16'h00F0 : 16'h0000;
            n_value = (k == 2) ? 16'h7000 : 16'h0010;
            fire(1'b1);
            chk_b(operand_error_flag, 1'b1, "bad pointer error");
            r1_indirect = 1'b0;
            c_indirect = 1'b0;
            n_indirect = 1'b0;
        end
        // Valid pointer forces the range into data memory
        put(MWS_AREA_DM, 1, 16'h0000);
        ops(1'b1, 16'h0010, MWS_AREA_IR, 16'h0010, MWS_AREA_IR, 16'h0000, MWS_AREA_DM);
        r1_indirect = 1'b1;
        fire(1'b1);
        chk_b(operand_error_flag, 1'b0, "good pointer error");
        chk_w(get(MWS_AREA_DM, 1), 16'h0012, "indirect range result");
        r1_indirect = 1'b0;
        $display("test indirect pointers over");
    endtask : t_indirect

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #200us;
        errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        end_sim();
    end
    initial begin
        errors = 0;
        n_compared = 0;
        srst = 1'b1;
        start = 1'b0;
        exec_cond = 1'b0;
        n_indirect = 1'b0;
        r1_indirect = 1'b0;
        c_indirect = 1'b0;
        ops(1'b1, 16'h0001, MWS_AREA_IR, 16'h0000, MWS_AREA_DM, 16'h0000, MWS_AREA_HR);
        repeat (3) @(negedge core_clk);
        srst = 1'b0;
        t_dm_hit();
        t_cnt_err();
        t_skip_miss();
        t_rel_hit();
        t_fetch();
        t_max();
        t_indirect();
        end_sim();
    end
endmodule : mws_word_search_bench

`default_nettype wire
